// *** eeprom_front_pkg.sv ***
`default_nettype none
package eeprom_front_pkg;
  // Geometry
  localparam int PAGE_COUNT = 128;
  localparam int PAGE_BYTES = 16;
  localparam int ADDR_BITS  = 11;
  localparam int BYTE_BITS  = 8;
  localparam int BITS_PER_XFER = 9;
  // Device address byte fields
  localparam int DEV_TYPE_HI = 7;
  localparam int DEV_TYPE_LO = 4;
  localparam int DEV_A10_POS = 3;
  localparam int DEV_A8_POS  = 1;
  localparam int DEV_RW_POS  = 0;
  // Type identifier default (arbitrary value)
  localparam logic [3:0] DEV_TYPE_DEFAULT = 4'h5;
  // Reset values
  localparam logic [3:0]  BIT_CNT_RESET = 4'h0;
  localparam logic [10:0] ADDR_RESET    = 11'h000;

  typedef enum logic [2:0] {
    ST_STANDBY  = 3'b000,
    ST_DEV_ADDR = 3'b001,
    ST_WORD_ADR = 3'b010,
    ST_RX_DATA  = 3'b011,
    ST_TX_DATA  = 3'b100,
    ST_IGNORE   = 3'b101
  } fe_state_t;

  // Decoded address results
  typedef struct packed {
    logic        valid;
    logic        read;
    logic [10:0] addr;
  } addr_info_t;

  // Received data byte event
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } rx_byte_t;
endpackage
`default_nettype wire

// *** eeprom_front.sv ***
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////
module eeprom_front
  import eeprom_front_pkg::*;
#(
  parameter logic [3:0] DEV_TYPE = DEV_TYPE_DEFAULT
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  // Bus pins
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  // Internal write cycle status
  input  wire logic        write_busy,
  // Data to transmit on reads
  input  wire logic [7:0]  tx_data,
  // Decoded results
  output addr_info_t       addr_info,
  output rx_byte_t         rx_byte,
  output logic             tx_load,
  output logic             stop_seen,
  output logic             standby
);

  // Elaboration checks
  if (PAGE_COUNT * PAGE_BYTES != (1 << ADDR_BITS)) begin : g_bad_geometry
    $error("array geometry does not match address width");
  end
  if (BITS_PER_XFER != BYTE_BITS + 1) begin : g_bad_slot
    $error("slot count must be one byte plus acknowledge");
  end
  if (DEV_TYPE_HI - DEV_TYPE_LO != 3) begin : g_bad_type_field
    $error("type field must be four bits wide");
  end
  if (DEV_A10_POS - DEV_A8_POS != ADDR_BITS - BYTE_BITS - 1) begin : g_bad_high_field
    $error("high address field width mismatch");
  end

  ////////////////////////////////////////////////////////////////////////
  // Helpers
  // True when the slot counter sits at the given slot
  function automatic logic at_slot(input logic [3:0] cnt, input int slot);
    return cnt == 4'(slot);
  endfunction

  // Open-drain pull request for one outgoing bit
  function automatic logic pull_for(input logic bit_val);
    return !bit_val;
  endfunction

  // States in which the block receives bytes and acknowledges them
  function automatic logic is_rx_state(input fe_state_t st);
    return (st == ST_DEV_ADDR) || (st == ST_WORD_ADR) || (st == ST_RX_DATA);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Synchronisers and edge detect
  // Second stage only feeds the logic
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic       scl_prev_q;
  logic       sda_prev_q;

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], scl_in};
      sda_sync_q <= {sda_sync_q[0], sda_in};
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
    end
  end

  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;

  always_comb begin
    scl_s    = scl_sync_q[1];
    sda_s    = sda_sync_q[1];
    scl_rise = scl_s & ~scl_prev_q;
    scl_fall = ~scl_s & scl_prev_q;
    start_ev = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
    stop_ev  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;
  end

  ////////////////////////////////////////////////////////////////////////
  // Byte framing
  fe_state_t  state_q;
  logic [3:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] tx_shift_q;
  logic       ack_slot;
  logic       last_bit;
  logic       rx_done;
  logic       first_fall_q;

  always_comb begin
    ack_slot = at_slot(bit_cnt_q, BYTE_BITS);
    last_bit = at_slot(bit_cnt_q, BYTE_BITS - 1);
    rx_done  = scl_rise && last_bit;
  end

  // The clock fall that closes a Start carries no bit
  always_ff @(posedge core_clk) begin
    if (sys_rst || stop_ev) begin
      first_fall_q <= 1'b0;
    end else if (start_ev) begin
      first_fall_q <= 1'b1;
    end else if (scl_fall) begin
      first_fall_q <= 1'b0;
    end
  end

  // Bit counter: 0..7 data, 8 acknowledge slot
  always_ff @(posedge core_clk) begin
    if (sys_rst || start_ev || stop_ev) begin
      bit_cnt_q <= BIT_CNT_RESET;
    end else if (scl_fall && state_q != ST_STANDBY && !first_fall_q) begin
      if (at_slot(bit_cnt_q, BITS_PER_XFER - 1)) begin
        bit_cnt_q <= BIT_CNT_RESET;
      end else if (scl_prev_q) begin
        bit_cnt_q <= bit_cnt_q + 4'h1;
      end
    end
  end

  // Input shift, MSb first
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      shift_q <= 8'h00;
    end else if (scl_rise && !ack_slot) begin
      shift_q <= {shift_q[6:0], sda_s};
    end
  end

  logic [7:0] rx_full;
  always_comb begin
    rx_full = {shift_q[6:0], sda_s};
  end

  ////////////////////////////////////////////////////////////////////////
  // Protocol state
  logic dev_match;
  always_comb begin
    dev_match = (rx_full[DEV_TYPE_HI:DEV_TYPE_LO] == DEV_TYPE) && !write_busy;
  end

  logic nack_q;
  // Start and Stop override the byte framing
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      state_q <= ST_STANDBY;
    end else if (stop_ev) begin
      state_q <= ST_STANDBY;
    end else if (start_ev) begin
      state_q <= write_busy ? ST_STANDBY : ST_DEV_ADDR;
    end else if (scl_fall && ack_slot) begin
      case (state_q)
        ST_DEV_ADDR: begin
          if (nack_q) begin
            state_q <= ST_IGNORE;
          end else if (addr_info.read) begin
            state_q <= ST_TX_DATA;
          end else begin
            state_q <= ST_WORD_ADR;
          end
        end
        ST_WORD_ADR: state_q <= ST_RX_DATA;
        ST_RX_DATA:  state_q <= ST_RX_DATA;
        ST_TX_DATA:  state_q <= nack_q ? ST_IGNORE : ST_TX_DATA;
        default:     state_q <= state_q;
      endcase
    end
  end

  // Acknowledge result, taken on the eighth rise for the device byte and on the ninth rise in reads
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      nack_q <= 1'b0;
    end else if (rx_done && state_q == ST_DEV_ADDR) begin
      nack_q <= !dev_match;
    end else if (scl_rise && ack_slot && state_q == ST_TX_DATA) begin
      nack_q <= sda_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Address decode and data events
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      addr_info <= '{valid: 1'b0, read: 1'b0, addr: ADDR_RESET};
    end else begin
      addr_info.valid <= 1'b0;
      if (rx_done && state_q == ST_DEV_ADDR && dev_match) begin
        addr_info.read  <= rx_full[DEV_RW_POS];
        addr_info.addr[ADDR_BITS-1:BYTE_BITS] <= rx_full[DEV_A10_POS:DEV_A8_POS];
        addr_info.valid <= rx_full[DEV_RW_POS];
      end
      if (rx_done && state_q == ST_WORD_ADR) begin
        addr_info.addr[BYTE_BITS-1:0] <= rx_full;
        addr_info.valid <= 1'b1;
      end
    end
  end

  // Received data byte events
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rx_byte <= '{valid: 1'b0, data: 8'h00};
    end else begin
      rx_byte.valid <= 1'b0;
      if (rx_done && state_q == ST_RX_DATA) begin
        rx_byte <= '{valid: 1'b1, data: rx_full};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Data line driver, changes only after clock falls or on Start and Stop
  logic load_pending;
  // Reload at the acknowledge fall unless the device byte was refused or the master refused
  always_comb begin
    load_pending = scl_fall && ack_slot && !nack_q &&
                   ((state_q == ST_DEV_ADDR && addr_info.read) || state_q == ST_TX_DATA);
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tx_shift_q <= 8'hFF;
    end else begin
      if (load_pending) begin
        tx_shift_q <= tx_data;
      end else if (scl_fall && state_q == ST_TX_DATA && !ack_slot) begin
        tx_shift_q <= {tx_shift_q[6:0], 1'b1};
      end
    end
  end

  // Load strobe for the byte source
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      tx_load <= 1'b0;
    end else begin
      tx_load <= load_pending;
    end
  end

  logic drive_low_d;
  always_comb begin
    drive_low_d = 1'b0;
    if (load_pending) begin
      // First bit of a read byte goes out on the acknowledge fall
      drive_low_d = pull_for(tx_data[7]);
    end else if (is_rx_state(state_q)) begin
      // Pull low for the acknowledge slot that this fall opens
      drive_low_d = last_bit && !(state_q == ST_DEV_ADDR && nack_q);
    end else if (state_q == ST_TX_DATA && !ack_slot && !last_bit) begin
      // Next bit after the shift that this fall performs
      drive_low_d = pull_for(tx_shift_q[6]);
    end else begin
      drive_low_d = 1'b0;
    end
  end

  // Output updated only on a clock fall or bus condition
  always_ff @(posedge core_clk) begin
    if (sys_rst || start_ev || stop_ev) begin
      sda_oe <= 1'b0;
    end else if (scl_fall) begin
      sda_oe <= drive_low_d;
    end
  end

  // Data line is never driven high
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  // Stop pulse
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      stop_seen <= 1'b0;
    end else begin
      stop_seen <= stop_ev;
    end
  end

  // Standby flag
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      standby <= 1'b1;
    end else begin
      standby <= (state_q == ST_STANDBY);
    end
  end

endmodule // eeprom_front
`default_nettype wire

// *** eeprom_front_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module eeprom_front_chk
  import eeprom_front_pkg::*;
(
  // Watched ports
  input wire logic       core_clk,
  input wire logic       sys_rst,
  input wire logic       scl_in,
  input wire logic       write_busy,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire addr_info_t addr_info,
  input wire logic       tx_load,
  input wire logic       stop_seen,
  input wire logic       standby
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_held;
    sda_oe [*6];
  endsequence
  AST_OPEN_DRAIN: assert property (!sda_out) else $error("data driven high");
  AST_RESET_IDLE: assert property (disable iff (1'b0) sys_rst |=> standby && !sda_oe)
    else $error("not idle after reset");
  AST_IDLE_QUIET: assert property (standby |-> !sda_oe) else $error("drive in standby");
  AST_STOP_END: assert property (stop_seen |-> ##[0:2] (standby && !sda_oe))
    else $error("stop not ending");
  AST_BUSY_DEAF: assert property (standby && write_busy |=> standby)
    else $error("woke while busy");
  AST_HIGH_STEADY: assert property ($rose(scl_in) |-> ##2 $stable(sda_oe) [*2])
    else $error("data moved in high phase");
  AST_ACK_HOLD: assert property ($rose(sda_oe) |-> s_held) else $error("drive too short");
  AST_READ_LOAD: assert property (addr_info.valid && addr_info.read |-> ##[1:40] tx_load)
    else $error("no load after read");
  AST_LOAD_ONCE: assert property (tx_load |=> !tx_load [*8]) else $error("load repeated");
endmodule // eeprom_front_chk
bind eeprom_front eeprom_front_chk u_chk (.core_clk(core_clk), .sys_rst(sys_rst), .scl_in(scl_in),
  .write_busy(write_busy), .sda_out(sda_out), .sda_oe(sda_oe), .addr_info(addr_info),
  .tx_load(tx_load), .stop_seen(stop_seen), .standby(standby));
`default_nettype wire

// *** eeprom_master_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module eeprom_master_model (
  // Clock and pins
  input  wire logic core_clk,
  input  wire logic sda_oe,
  output logic      scl,
  output logic      sda
);
  logic sda_m = 1'b1;
  assign sda = sda_m & ~sda_oe; // Pull-up wired AND
  initial scl = 1'b1; // Idle both high
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic start;
    sda_m = 1'b1;
    tick(4);
    scl = 1'b1;
    tick(2);
    sda_m = 1'b0;
    tick(2);
    scl = 1'b0;
  endtask
  task automatic stop;
    sda_m = 1'b0;
    tick(2);
    scl = 1'b1;
    tick(2);
    sda_m = 1'b1;
    tick(2);
  endtask
  task automatic bitx(input logic b, output logic r);
    tick(2);
    sda_m = b;
    tick(2);
    scl = 1'b1;
    tick(2);
    r = sda;
    tick(2);
    scl = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] q, output logic k);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(a, k);
  endtask
endmodule // eeprom_master_model
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import eeprom_front_pkg::*;
  localparam logic [7:0] DEV = {DEV_TYPE_DEFAULT, 4'hA};
  logic       core_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       write_busy = 1'b0;
  logic [7:0] tx_data = 8'hC3;
  logic       scl, sda, sda_out, sda_oe, tx_load, stop_seen, standby, k;
  logic       stop_q = 1'b0;
  logic [7:0] q;
  addr_info_t addr_info, ai_q;
  rx_byte_t   rx_byte, rx_q;
  int         failures = 0;
  int         n_compared = 0;
  always #50 core_clk = ~core_clk;
  eeprom_master_model m (.core_clk(core_clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
  eeprom_front dut (.core_clk(core_clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .write_busy(write_busy), .tx_data(tx_data), .addr_info(addr_info), .rx_byte(rx_byte),
    .tx_load(tx_load), .stop_seen(stop_seen), .standby(standby));
  always @(posedge core_clk) begin
    if (addr_info.valid) ai_q <= addr_info;
    if (rx_byte.valid) rx_q <= rx_byte;
    if (stop_seen) stop_q <= 1'b1;
  end
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic t_write;
    m.start();
    m.xfer(DEV, 1'b1, q, k);
    chk("dev ack", k, 16'h0000);
    chk("awake", standby, 16'h0000);
    m.xfer(8'h3C, 1'b1, q, k);
    chk("addr", ai_q, 16'h153C);
    m.xfer(8'hA5, 1'b1, q, k);
    chk("data 1", rx_q.data, 16'h00A5);
    m.xfer(8'h0F, 1'b1, q, k);
    chk("data 2", rx_q.data, 16'h000F);
    m.stop();
    m.tick(4);
    chk("stop", stop_q, 16'h0001);
    chk("standby", standby, 16'h0001);
  endtask
  task automatic t_read;
    m.start();
    m.xfer(DEV, 1'b1, q, k);
    m.xfer(8'h7E, 1'b1, q, k);
    m.start();
    m.xfer(DEV | 8'h01, 1'b1, q, k);
    chk("rd ack", k, 16'h0000);
    chk("rd dir", ai_q.read, 16'h0001);
    m.xfer(8'hFF, 1'b0, q, k);
    chk("rd 1", q, 16'h00C3);
    m.xfer(8'hFF, 1'b1, q, k);
    chk("rd 2", q, 16'h00C3);
    m.tick(8);
    chk("release", sda_oe, 16'h0000);
    m.stop();
  endtask
  task automatic t_reject;
    m.start();
    m.xfer(DEV ^ 8'h80, 1'b1, q, k);
    chk("bad type", k, 16'h0001);
    m.xfer(8'h00, 1'b1, q, k);
    chk("ignored", k, 16'h0001);
    m.stop();
    write_busy = 1'b1;
    m.start();
    m.xfer(DEV, 1'b1, q, k);
    chk("busy", k, 16'h0001);
    m.stop();
    write_busy = 1'b0;
  endtask
  initial begin
    repeat (2) @(negedge core_clk);
    sys_rst = 1'b0;
    m.tick(4);
    chk("reset", {standby, sda_oe}, 16'h0002);
    t_write();
    t_read();
    t_reject();
    final_report();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    final_report();
  end
endmodule // tb_top
`default_nettype wire
